// ===== core/srpu_unit.sv
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module srpu_unit #(
    parameter logic [19:0] SEG_WINDOW = srpu_pkg::SEG_WINDOW_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic init_req,
    input wire logic [31:0] processor_state_word,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic req_fetch,
    input wire logic [31:0] req_wdata,
    input wire logic instr_done,
    input wire logic status_clear,
    output logic mem_valid,
    output logic [19:0] mem_addr,
    output logic mem_write,
    output logic [31:0] mem_wdata,
    output logic req_abort,
    output logic fault_irq,
    output srpu_pkg::srpu_code_t fault_code
);
    import srpu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register space decoding and byte-lane merging.

    function automatic logic is_seg(input logic [11:0] a);
        is_seg = (a[11:6] == OFF_SEG[11:6]);
    endfunction

    function automatic logic is_status(input logic [11:0] a);
        is_status = (a[11:2] == OFF_STATUS[11:2]);
    endfunction

    // Byte-lane merge for partial bus writes to a segment register.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // Sixteen segment registers, indexed by the top four program-address bits.
    logic [31:0] seg_regs [16];
    logic [19:0] fault_addr;
    logic mapper_on;
    logic wi_pending;
    logic write_block;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    ////////////////////////////////////////////////////////////////////////////
    // Address path.

    wire logic [19:0] prog_addr = req_addr[19:0];
    // Initialize overrides the status word for an access in the same cycle.
    wire logic map_on = processor_state_word[PSW_MAP_BIT] && !init_req;
    wire logic [3:0] seg_select_index = prog_addr[19:16];
    wire logic [31:0] seg_sel = seg_regs[seg_select_index];
    wire logic [15:0] block_offset = prog_addr[15:0];
    wire logic [7:0] segment_limit = seg_sel[SEG_LIM_LSB +: SEG_LIM_W];
    wire logic [11:0] segment_base = seg_sel[SEG_BASE_LSB +: SEG_BASE_W];
    wire logic [1:0] store_guard_field = seg_sel[SEG_GUARD_LSB +: 2];
    wire logic [19:0] block_base = {segment_base, 8'h00};
    wire logic [19:0] phys_addr = block_base + {4'h0, block_offset};

    ////////////////////////////////////////////////////////////////////////////
    // Protection checks, in priority order.

    wire logic f_np = !seg_sel[SEG_PRES_BIT];
    wire logic f_lim = prog_addr[15:8] > segment_limit;
    wire logic f_ex = req_fetch && seg_sel[SEG_EXEC_BIT];
    wire logic f_wp = req_write && store_guard_field[0];
    wire logic f_wi = req_write && (store_guard_field == GUARD_INT);
    // An access that breaks several checks reports only the first one in this order.
    wire srpu_code_t abort_code = f_np ? SRPU_CODE_NOT_PRESENT :
                                  f_lim ? SRPU_CODE_LIMIT :
                                  f_ex ? SRPU_CODE_EXECUTE :
                                  f_wp ? SRPU_CODE_WRITE_PROT : SRPU_CODE_NONE;
    wire logic checked = req_valid && map_on;
    wire logic hit_abort = checked && (abort_code != SRPU_CODE_NONE);
    wire logic hit_wi = checked && f_wi && !hit_abort;
    // Stores into the dedicated window load a segment register and still reach memory.
    wire logic seg_load = req_valid && !map_on && req_write &&
                          (prog_addr[19:6] == SEG_WINDOW[19:6]);

    ////////////////////////////////////////////////////////////////////////////
    // Fault status.

    wire logic axi_wr = aw_held && w_held && !s_axi_bvalid;
    wire logic axi_clear = axi_wr && is_status(aw_addr) && w_strb[0] && w_data[0];
    wire logic clr = status_clear || axi_clear;
    wire logic irq_free = !fault_irq || clr;
    wire logic set_abort = hit_abort && irq_free;
    wire logic set_wi = !hit_abort && wi_pending && instr_done && irq_free;
    wire logic set_any = set_abort || set_wi;
    wire logic next_wi_pending = (wi_pending && !instr_done) || hit_wi;
    wire srpu_code_t next_fault_code = set_abort ? abort_code : SRPU_CODE_WRITE_INT;
    wire logic next_write_block = set_abort && (abort_code != SRPU_CODE_NOT_PRESENT);

    always_ff @(posedge aclk) begin
        if (!aresetn || init_req) begin
            wi_pending <= 1'b0;
        end else begin
            wi_pending <= next_wi_pending;
        end
    end

    // The program address on the request port when a fault is recorded, for the handler.
    always_ff @(posedge aclk) begin
        if (!aresetn || init_req) begin
            fault_addr <= 20'h00000;
        end else if (set_any) begin
            fault_addr <= prog_addr;
        end
    end

    // A new fault wins over a clear in the same cycle, so the clear never discards it.
    always_ff @(posedge aclk) begin
        if (!aresetn || init_req) begin
            fault_irq <= 1'b0;
            fault_code <= SRPU_CODE_NONE;
            write_block <= 1'b0;
        end else if (set_any) begin
            fault_irq <= 1'b1;
            fault_code <= next_fault_code;
            write_block <= next_write_block;
        end else if (clr) begin
            fault_irq <= 1'b0;
            fault_code <= SRPU_CODE_NONE;
            write_block <= 1'b0;
        end
    end

    // Mapper state as last seen by an access, reported in the status word.
    always_ff @(posedge aclk) begin
        if (!aresetn || init_req) begin
            mapper_on <= 1'b0;
        end else if (req_valid) begin
            mapper_on <= map_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory request pipeline, one access per cycle.

    // Every access is answered one cycle later, so translation never stalls a requester.
    wire logic next_mem_valid = req_valid && !hit_abort;
    wire logic [19:0] next_mem_addr = map_on ? phys_addr : prog_addr;
    wire logic next_mem_write = next_mem_valid && req_write && !write_block;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_valid <= 1'b0;
            mem_addr <= 20'h00000;
            mem_write <= 1'b0;
            mem_wdata <= 32'h00000000;
            req_abort <= 1'b0;
        end else begin
            mem_valid <= next_mem_valid;
            mem_addr <= next_mem_addr;
            mem_write <= next_mem_write;
            mem_wdata <= req_wdata;
            req_abort <= hit_abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment registers.

    wire logic axi_seg_wr = axi_wr && is_seg(aw_addr);
    wire logic [3:0] bus_index = aw_addr[5:2];
    wire logic [3:0] snoop_index = prog_addr[5:2];
    wire logic [31:0] bus_merged = merge(seg_regs[bus_index], w_data, w_strb) & SEG_WRITE_MASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) begin
                seg_regs[i] <= SEG_RESET;
            end
        end else if (seg_load) begin
            seg_regs[snoop_index] <= req_wdata & SEG_WRITE_MASK;
        end else if (axi_seg_wr) begin
            seg_regs[bus_index] <= bus_merged;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels.

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic b_done = s_axi_bvalid && s_axi_bready;
    wire logic next_aw_held = !axi_wr && (aw_held || aw_take);
    wire logic next_w_held = !axi_wr && (w_held || w_take);
    wire logic next_bvalid = axi_wr || (s_axi_bvalid && !b_done);
    wire logic wr_mapped = is_seg(aw_addr) || is_status(aw_addr);

    // The ready outputs are registered copies of what the held flags and the pending write response allow in the next cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
        end
    end

    // Address and data are captured only on their own handshakes; the response is set when the write is performed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (axi_wr) begin
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels.

    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic r_done = s_axi_rvalid && s_axi_rready;
    wire logic next_rvalid = ar_take || (s_axi_rvalid && !r_done);

    // Status word layout: cause code, pending fault, write/interrupt pending, mapper on.
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h00000000;
        status_word[2:0] = fault_code;
        status_word[STAT_PEND_BIT] = fault_irq;
        status_word[STAT_WI_BIT] = wi_pending;
        status_word[STAT_MAP_BIT] = mapper_on;
    end

    wire logic rd_seg = is_seg(s_axi_araddr);
    wire logic rd_stat = is_status(s_axi_araddr);
    wire logic rd_faddr = (s_axi_araddr[11:2] == OFF_FAULT_ADDR[11:2]);
    wire logic rd_hit = rd_seg || rd_stat || rd_faddr;
    wire logic [31:0] rd_data = rd_seg ? seg_regs[s_axi_araddr[5:2]] :
                                rd_stat ? status_word :
                                rd_faddr ? {12'h000, fault_addr} : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== pkg/srpu_pkg.sv
// Function
// - Status-word bit 21 low: no translation, no checks; high: every address is relocated. The code uses bit 10 (PSW_MAP_BIT).
// - Upper twelve bits of a 32-bit effective address are ignored; low 20 used.
// - Shorter addresses are zero-extended on the high side to 20 bits.
// - Top four program-address bits pick one of sixteen segment registers.
// - Segment base field times 256 gives the block base address.
// - Physical address is base plus the low sixteen program-address bits.
// - A selected register with presence clear raises a fault.
// - Store guard 01 or 11 faults a store and the store is dropped.
// - Store guard 10 lets the store finish, then faults after the instruction.
// - Execute-protect bit faults an instruction fetch from the segment.
// - Program bits below the select field above the limit raise a limit fault.
// - Every fault records a cause code in the interrupt status register. The code records none for a fault raised while one is pending.
// - After execute, write or limit faults, writes are suppressed until cleared.
// - Fault stays pending until cleared; processor delivers the code in register 13.
// - Translation and checks add no throughput penalty to any requester.
// - Segment register holds limit, base, execute, store guard and presence fields.
// - Interrupt status is cleared after the handler has copied it.
// - Initialize disables mapping and faults; next reference follows bit 21 again. The code follows bit 10.
// - Segment registers load by stores to dedicated locations while mapping is off.
package srpu_pkg;
    localparam int PSW_MAP_BIT = 10;
    localparam int ADDR_W = 20;
    localparam int SEG_LIM_LSB = 20;
    localparam int SEG_LIM_W = 8;
    localparam int SEG_BASE_LSB = 8;
    localparam int SEG_BASE_W = 12;
    localparam int SEG_EXEC_BIT = 7;
    localparam int SEG_GUARD_LSB = 5;
    localparam int SEG_PRES_BIT = 4;
    localparam logic [31:0] SEG_WRITE_MASK = 32'h0FFFFFF0;
    localparam logic [31:0] SEG_RESET = 32'h00000000;
    localparam logic [19:0] SEG_WINDOW_DEF = 20'h00300;
    localparam logic [1:0] GUARD_INT = 2'h2;
    localparam logic [11:0] OFF_SEG = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h040;
    localparam logic [11:0] OFF_FAULT_ADDR = 12'h044;
    localparam int STAT_PEND_BIT = 8;
    localparam int STAT_WI_BIT = 9;
    localparam int STAT_MAP_BIT = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        SRPU_CODE_NONE,
        SRPU_CODE_NOT_PRESENT,
        SRPU_CODE_LIMIT,
        SRPU_CODE_EXECUTE,
        SRPU_CODE_WRITE_PROT,
        SRPU_CODE_WRITE_INT
    } srpu_code_t;
endpackage

// ===== verif/segment_relocation_protection_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module segment_relocation_protection_unit_test;
    import srpu_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, init_req = 1'b0;
    logic [31:0] processor_state_word = 32'h0, s_axi_wdata = 32'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_valid, req_write, req_fetch;
    logic instr_done, status_clear, mem_valid, mem_write, req_abort, fault_irq, hs, fin;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, req_addr, req_wdata, mem_wdata, rd;
    logic [19:0] mem_addr;
    srpu_code_t fault_code;
    int n_errors = 0, compares = 0, cycles = 0;
    always #5 aclk = ~aclk;
    srpu_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .init_req, .processor_state_word,
        .req_valid, .req_addr, .req_write, .req_fetch, .req_wdata, .instr_done, .status_clear, .mem_valid,
        .mem_addr, .mem_write, .mem_wdata, .req_abort, .fault_irq, .fault_code);
    srpu_requester cpu (.aclk, .req_valid, .req_addr, .req_write, .req_fetch, .req_wdata, .instr_done, .status_clear);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awready;
            w = s_axi_wready;
            fin = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!fin);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            hs = s_axi_arready;
            fin = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (hs) s_axi_arvalid <= 1'b0;
        end while (!fin);
        s_axi_rready <= 1'b0;
    endtask
    task automatic acc(input logic [31:0] a, input logic [1:0] k, input logic [22:0] e);
        cpu.drive(1'b1, a, k, 1'b0, 1'b0);
        chk($sformatf("access %h", a), {9'h0, e}, {9'h0, mem_valid, req_abort, mem_write, mem_valid ? mem_addr : 20'h0});
        chk($sformatf("wdata %h", a), ~a, mem_wdata);
    endtask
    task automatic fchk(input logic irq, input srpu_code_t c);
        chk("fault", {28'h0, irq, c}, {28'h0, fault_irq, fault_code});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFF_SEG + 12'h00C);
        chk("seg3 reset", SEG_RESET, rd);
        axi_wr(OFF_SEG + 12'h00C, 32'hFFF7421F);
        chk("write response", {30'h0, RESP_OKAY}, {30'h0, rs});
        axi_rd(OFF_SEG + 12'h00C);
        chk("seg3", 32'h0FF74210, rd);
        axi_wr(OFF_SEG + 12'h028, 32'h000130B0);
        axi_wr(OFF_SEG + 12'h03C, 32'h01F0F050);
        axi_rd(12'h048);
        chk("bad address response", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("bad address data", 32'h0, rd);
        axi_wr(12'h048, 32'h12345678);
        chk("bad write response", {30'h0, RESP_SLVERR}, {30'h0, rs});
        acc(32'hFFF3234A, 2'b00, 23'h43234A);
        acc(32'h00100, 2'b10, 23'h500100);
        acc(32'h00304, 2'b10, 23'h500304);
        acc(32'h00304, 2'b00, 23'h400304);
        axi_rd(OFF_SEG + 12'h004);
        chk("seg1 loaded", 32'h0FFFFCF0, rd);
        $display("test registers and unmapped done");
        @(posedge aclk);
        processor_state_word <= 32'h00000400;
        acc(32'hFFF3234A, 2'b00, 23'h47654A);
        acc(32'hF1FFC, 2'b00, 23'h410FFC);
        acc(32'hF1200, 2'b10, 23'h510200);
        fchk(1'b0, SRPU_CODE_NONE);
        cpu.drive(1'b0, 32'h0, 2'b00, 1'b0, 1'b1);
        fchk(1'b1, SRPU_CODE_WRITE_INT);
        axi_rd(OFF_STATUS);
        chk("status", 32'h00010105, rd);
        cpu.drive(1'b0, 32'h0, 2'b00, 1'b1, 1'b0);
        fchk(1'b0, SRPU_CODE_NONE);
        acc(32'h50000, 2'b10, 23'h200000);
        fchk(1'b1, SRPU_CODE_NOT_PRESENT);
        acc(32'h30004, 2'b10, 23'h574204);
        acc(32'hA0100, 2'b01, 23'h200000);
        fchk(1'b1, SRPU_CODE_NOT_PRESENT);
        cpu.drive(1'b0, 32'h0, 2'b00, 1'b1, 1'b0);
        acc(32'hA0100, 2'b01, 23'h200000);
        fchk(1'b1, SRPU_CODE_LIMIT);
        axi_rd(OFF_FAULT_ADDR);
        chk("fault address", 32'h000A0100, rd);
        acc(32'h30008, 2'b10, 23'h474208);
        axi_wr(OFF_STATUS, 32'h00000001);
        fchk(1'b0, SRPU_CODE_NONE);
        acc(32'h30008, 2'b10, 23'h574208);
        acc(32'hA0000, 2'b01, 23'h200000);
        fchk(1'b1, SRPU_CODE_EXECUTE);
        cpu.drive(1'b0, 32'h0, 2'b00, 1'b1, 1'b0);
        acc(32'hA0001, 2'b10, 23'h200000);
        fchk(1'b1, SRPU_CODE_WRITE_PROT);
        acc(32'hA0001, 2'b00, 23'h413001);
        $display("test protection done");
        @(posedge aclk);
        init_req <= 1'b1;
        acc(32'h3234A, 2'b00, 23'h43234A);
        fchk(1'b0, SRPU_CODE_NONE);
        @(posedge aclk);
        init_req <= 1'b0;
        acc(32'h3234A, 2'b00, 23'h47654A);
        $display("test initialize done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== verif/srpu_requester.sv
`timescale 1ns/1ps
`default_nettype none
module srpu_requester (
    input wire logic aclk,
    output logic req_valid = 1'b0,
    output logic [31:0] req_addr = 32'h00000000,
    output logic req_write = 1'b0,
    output logic req_fetch = 1'b0,
    output logic [31:0] req_wdata = 32'h00000000,
    output logic instr_done = 1'b0,
    output logic status_clear = 1'b0
);
    // One cycle of processor activity; results are settled at the falling edge half a cycle after it ends.
    task automatic drive(input logic v, input logic [31:0] a, input logic [1:0] k, input logic c, input logic d);
        @(posedge aclk);
        req_valid <= v;
        req_addr <= a;
        req_write <= k[1];
        req_fetch <= k[0];
        req_wdata <= ~a;
        status_clear <= c;
        instr_done <= d;
        @(posedge aclk);
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_wdata <= a;
        status_clear <= 1'b0;
        instr_done <= 1'b0;
        @(negedge aclk);
    endtask
endmodule
`default_nettype wire

// ===== verif/srpu_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module srpu_unit_properties
    import srpu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic init_req,
    input wire logic [31:0] processor_state_word,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic status_clear,
    input wire logic s_axi_bvalid,
    input wire logic mem_valid,
    input wire logic [19:0] mem_addr,
    input wire logic mem_write,
    input wire logic req_abort,
    input wire logic fault_irq,
    input wire srpu_pkg::srpu_code_t fault_code
);
    wire logic [19:0] low_addr = req_addr[19:0];
    wire logic clr_any = status_clear || init_req;
    wire logic plain = req_valid && (!processor_state_word[PSW_MAP_BIT] || init_req);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_answer_next: assert property (req_valid |=> mem_valid != req_abort)
        else $error("access not answered");
    chk_no_stray: assert property ((mem_valid || req_abort) |-> $past(req_valid))
        else $error("answer without access");
    chk_plain_addr: assert property (plain |=> mem_valid && mem_addr == $past(low_addr))
        else $error("unmapped address altered");
    chk_store_only: assert property (mem_write |-> mem_valid && $past(req_write))
        else $error("memory write without store");
    chk_abort_logged: assert property (req_abort |-> fault_irq && fault_code != SRPU_CODE_NONE)
        else $error("abort without fault");
    chk_code_irq: assert property (fault_code != SRPU_CODE_NONE |-> fault_irq)
        else $error("code without fault");
    chk_irq_held:
        assert property ($fell(fault_irq) |-> $past(clr_any) || $rose(s_axi_bvalid))
        else $error("fault dropped without clear");
    chk_code_kept:
        assert property (fault_irq && $past(fault_irq) && !$past(clr_any) && !$rose(s_axi_bvalid) |-> $stable(fault_code))
        else $error("fault code overwritten");
endmodule
bind srpu_unit srpu_unit_properties chk (.aclk, .aresetn, .init_req, .processor_state_word, .req_valid, .req_addr,
    .req_write, .status_clear, .s_axi_bvalid, .mem_valid, .mem_addr, .mem_write, .req_abort, .fault_irq, .fault_code);
`default_nettype wire
